// ---- design/nac_pkg.sv ----
// Constants for the nonvolatile byte array access block.
// Assumes a 200 MHz system clock and a 32-bit AXI4-Lite register bus.
// Operation
// - Twelve address bits select one of 4096 bytes
// - Reserved address and control bits read zero
// - Data register feeds writes, receives read bytes
// - Mode field picks atomic, erase or write
// - Mode field frozen while programming strobe set
// - Reset clears mode unless programming in progress
// - Ready interrupt while enabled and strobe clear
// - Strobe starts programming only inside enable window
// - Master enable self-clears four cycles after set
// - Strobe stays set for whole programming time
// - Programming start stalls processor two cycles
// - No programming start while flash self-program busy
// - Read strobe fetches byte, stalls four cycles
// - No reads or address changes while programming
package nac_pkg;
  localparam int unsigned AXI_AW        = 8;
  localparam int unsigned AXI_DW        = 32;
  localparam int unsigned NVM_AW        = 12;
  localparam int unsigned NVM_DEPTH     = 4096;
  localparam int unsigned TMR_W         = 20;
  // Register indices; byte address is four times the index
  localparam logic [5:0]  IDX_CTRL      = 6'h1F;
  localparam logic [5:0]  IDX_DATA      = 6'h20;
  localparam logic [5:0]  IDX_ADDR_LO   = 6'h21;
  localparam logic [5:0]  IDX_ADDR_HI   = 6'h22;
  localparam logic [5:0]  IDX_CFG       = 6'h23;
  localparam logic [5:0]  IDX_STATUS    = 6'h24;
  localparam logic [5:0]  IDX_MASK      = 6'h25;
  // Control field positions
  localparam int unsigned CTRL_RE       = 0;
  localparam int unsigned CTRL_PE       = 1;
  localparam int unsigned CTRL_MPE      = 2;
  localparam int unsigned CTRL_RIE      = 3;
  localparam int unsigned CTRL_PM_LO    = 4;
  localparam int unsigned CTRL_PM_HI    = 5;
  // Config field positions
  localparam int unsigned CFG_GIE       = 0;
  localparam int unsigned CFG_SPB       = 1;
  // Event bits
  localparam int unsigned EV_PROG_DONE  = 0;
  localparam int unsigned EV_READ_DONE  = 1;
  localparam int unsigned EV_REFUSED    = 2;
  localparam int unsigned EV_W          = 3;
  // Program modes
  localparam logic [1:0]  PM_ATOMIC     = 2'h0;
  localparam logic [1:0]  PM_ERASE      = 2'h1;
  localparam logic [1:0]  PM_WRITE      = 2'h2;
  localparam logic [1:0]  PM_RSVD       = 2'h3;
  // Reset values
  localparam logic [1:0]  RST_MODE      = 2'h0;
  localparam logic [7:0]  RST_DATA      = 8'h00;
  localparam logic [11:0] RST_ADDR      = 12'h000;
  localparam logic [7:0]  ERASED_BYTE   = 8'hFF;
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned T_ATOMIC_NS   = 3400000;
  localparam int unsigned T_SPLIT_NS    = 1800000;
  localparam logic [TMR_W-1:0] ATOMIC_CYC =
    TMR_W'(T_ATOMIC_NS / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] SPLIT_CYC  =
    TMR_W'(T_SPLIT_NS / CLK_PERIOD_NS);
  localparam logic [1:0]  MPE_WINDOW    = 2'h3;
  localparam logic [2:0]  STALL_PROG    = 3'h2;
  localparam logic [2:0]  STALL_READ    = 3'h4;
  // AXI responses
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  typedef enum logic {ENG_IDLE, ENG_PROG} nac_eng_t;
endpackage

// ---- design/nac_top.sv ----
// Nonvolatile byte array with its access control and AXI4-Lite slave.
// Assumes one clock; por only resets the programming engine.
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module nac_top #(
  parameter logic [nac_pkg::TMR_W-1:0] PROG_ATOMIC_CYC = nac_pkg::ATOMIC_CYC,
  parameter logic [nac_pkg::TMR_W-1:0] PROG_SPLIT_CYC  = nac_pkg::SPLIT_CYC
) (
  input  wire  logic                        clk,
  input  wire  logic                        rst,
  input  wire  logic                        por,
  input  wire  logic [nac_pkg::AXI_AW-1:0]  s_axi_awaddr,
  input  wire  logic                        s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire  logic [nac_pkg::AXI_DW-1:0]  s_axi_wdata,
  input  wire  logic [3:0]                  s_axi_wstrb,
  input  wire  logic                        s_axi_wvalid,
  output logic                              s_axi_wready,
  output logic [1:0]                        s_axi_bresp,
  output logic                              s_axi_bvalid,
  input  wire  logic                        s_axi_bready,
  input  wire  logic [nac_pkg::AXI_AW-1:0]  s_axi_araddr,
  input  wire  logic                        s_axi_arvalid,
  output logic                              s_axi_arready,
  output logic [nac_pkg::AXI_DW-1:0]        s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  output logic                              s_axi_rvalid,
  input  wire  logic                        s_axi_rready,
  input  wire  logic                        self_program_busy,
  output logic                              irq,
  output logic                              ready_irq,
  output logic                              cpu_stall
);
  localparam int unsigned TW = nac_pkg::TMR_W;
  localparam int unsigned EW = nac_pkg::EV_W;

  logic [7:0]           mem [nac_pkg::NVM_DEPTH];

  // Bus side state
  logic                 aw_full_q, aw_full_d;
  logic [5:0]           aw_idx_q, aw_idx_d;
  logic                 w_full_q, w_full_d;
  logic [7:0]           wdat_q, wdat_d;
  logic                 wstb_q, wstb_d;
  logic                 awready_q, awready_d;
  logic                 wready_q, wready_d;
  logic                 bvalid_q, bvalid_d;
  logic [1:0]           bresp_q, bresp_d;
  logic                 arready_q, arready_d;
  logic                 rvalid_q, rvalid_d;
  logic [31:0]          rdata_q, rdata_d;
  logic [1:0]           rresp_q, rresp_d;
  logic [5:0]           rd_idx_q, rd_idx_d;

  // Register state
  logic [7:0]           data_q, data_d;
  logic [11:0]          addr_q, addr_d;
  logic                 rie_q, rie_d;
  logic                 mpe_q, mpe_d;
  logic [1:0]           mpe_cnt_q, mpe_cnt_d;
  logic                 re_q, re_d;
  logic                 gie_q, gie_d;
  logic [EW-1:0]        ev_q, ev_d;
  logic [EW-1:0]        mask_q, mask_d;
  logic [2:0]           stall_cnt_q, stall_cnt_d;
  logic                 cpu_stall_q, cpu_stall_d;
  logic                 irq_q, irq_d;
  logic                 rdy_q, rdy_d;

  // Engine state, survives system reset except mode, which reset clears when idle
  nac_pkg::nac_eng_t    eng_q, eng_d;
  logic [1:0]           mode_q, mode_d;
  logic [TW-1:0]        tmr_q, tmr_d;
  logic [11:0]          pa_q, pa_d;
  logic [7:0]           pd_q, pd_d;
  logic [TW-1:0]        el_q, el_d;

  // Decode and strobes
  logic                 wr_go;
  logic                 wr_ok;
  logic                 ctrl_wr;
  logic                 pe_req;
  logic                 start_ok;
  logic                 rd_req;
  logic                 prog_done;
  logic                 mem_we;
  logic [7:0]           mem_wd;
  logic [7:0]           mem_old;
  logic [7:0]           mem_rd;
  logic [EW-1:0]        ev_set;
  logic [EW-1:0]        ev_clr;
  logic                 busy;

  function automatic logic idx_ok(input logic [5:0] idx);
    idx_ok = (idx >= nac_pkg::IDX_CTRL) && (idx <= nac_pkg::IDX_MASK);
  endfunction

  assign busy    = (eng_q == nac_pkg::ENG_PROG);
  assign mem_old = mem[pa_q];
  assign mem_rd  = mem[addr_q];

  always_comb begin
    logic [31:0] rv;
    rv = 32'h0000_0000;
    // Write channel capture, either order
    aw_full_d = aw_full_q;
    aw_idx_d  = aw_idx_q;
    w_full_d  = w_full_q;
    wdat_d    = wdat_q;
    wstb_d    = wstb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    wr_go     = aw_full_q && w_full_q && !bvalid_q;
    wr_ok     = wr_go && idx_ok(aw_idx_q);
    if (s_axi_awvalid && awready_q) begin
      aw_full_d = 1'b1;
      aw_idx_d  = s_axi_awaddr[7:2];
    end else if (wr_go) begin
      aw_full_d = 1'b0;
    end
    if (s_axi_wvalid && wready_q) begin
      w_full_d = 1'b1;
      wdat_d   = s_axi_wdata[7:0];
      wstb_d   = s_axi_wstrb[0];
    end else if (wr_go) begin
      w_full_d = 1'b0;
    end
    if (wr_go) begin
      bvalid_d = 1'b1;
      bresp_d  = wr_ok ? nac_pkg::RESP_OKAY : nac_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    awready_d = !aw_full_d;
    wready_d  = !w_full_d;

    // Register writes
    ctrl_wr = wr_ok && wstb_q && (aw_idx_q == nac_pkg::IDX_CTRL);
    data_d  = data_q;
    addr_d  = addr_q;
    gie_d   = gie_q;
    mask_d  = mask_q;
    ev_clr  = '0;
    if (wr_ok && wstb_q) begin
      unique case (aw_idx_q)
        nac_pkg::IDX_DATA:    data_d = wdat_q;
        nac_pkg::IDX_ADDR_LO: if (!busy) addr_d[7:0] = wdat_q;
        nac_pkg::IDX_ADDR_HI: if (!busy) addr_d[11:8] = wdat_q[3:0];
        nac_pkg::IDX_CFG:     gie_d = wdat_q[nac_pkg::CFG_GIE];
        nac_pkg::IDX_STATUS:  ev_clr = wdat_q[EW-1:0];
        nac_pkg::IDX_MASK:    mask_d = wdat_q[EW-1:0];
        default: ;
      endcase
    end

    // Mode field: frozen while busy, cleared by reset when idle
    mode_d = mode_q;
    if (rst && !busy) begin
      mode_d = nac_pkg::RST_MODE;
    end else if (ctrl_wr && !busy) begin
      mode_d = wdat_q[nac_pkg::CTRL_PM_HI:nac_pkg::CTRL_PM_LO];
    end
    rie_d = ctrl_wr ? wdat_q[nac_pkg::CTRL_RIE] : rie_q;

    // Master enable window
    mpe_d     = mpe_q;
    mpe_cnt_d = mpe_cnt_q;
    if (mpe_q) begin
      if (mpe_cnt_q == 2'h0) begin
        mpe_d = 1'b0;
      end else begin
        mpe_cnt_d = mpe_cnt_q - 2'h1;
      end
    end else if (ctrl_wr && wdat_q[nac_pkg::CTRL_MPE]) begin
      mpe_d     = 1'b1;
      mpe_cnt_d = nac_pkg::MPE_WINDOW;
    end

    // Programming start
    pe_req   = ctrl_wr && wdat_q[nac_pkg::CTRL_PE] && !busy;
    start_ok = pe_req && mpe_q && !self_program_busy
               && (mode_d != nac_pkg::PM_RSVD);
    rd_req   = ctrl_wr && wdat_q[nac_pkg::CTRL_RE] && !busy
               && !start_ok;
    re_d     = rd_req;

    // Engine
    eng_d     = eng_q;
    tmr_d     = tmr_q;
    pa_d      = pa_q;
    pd_d      = pd_q;
    prog_done = 1'b0;
    unique case (eng_q)
      nac_pkg::ENG_IDLE: begin
        if (start_ok) begin
          eng_d = nac_pkg::ENG_PROG;
          tmr_d = ((mode_d == nac_pkg::PM_ATOMIC) ? PROG_ATOMIC_CYC
                  : PROG_SPLIT_CYC) - TW'(1);
          pa_d  = addr_q;
          pd_d  = data_q;
        end
      end
      nac_pkg::ENG_PROG: begin
        if (tmr_q == '0) begin
          eng_d     = nac_pkg::ENG_IDLE;
          prog_done = 1'b1;
        end else begin
          tmr_d = tmr_q - TW'(1);
        end
      end
    endcase
    el_d = busy ? el_q + TW'(1) : '0;

    // Array update at the end of the programming time
    mem_we = prog_done;
    unique case (mode_q)
      nac_pkg::PM_ERASE: mem_wd = nac_pkg::ERASED_BYTE;
      nac_pkg::PM_WRITE: mem_wd = mem_old & pd_q;
      default:           mem_wd = pd_q;
    endcase

    // Read fetch one cycle after the strobe write
    if (re_q) begin
      data_d = mem_rd;
    end

    // Processor stall
    stall_cnt_d = stall_cnt_q;
    if (start_ok) begin
      stall_cnt_d = nac_pkg::STALL_PROG;
    end else if (re_q) begin
      stall_cnt_d = nac_pkg::STALL_READ;
    end else if (stall_cnt_q != 3'h0) begin
      stall_cnt_d = stall_cnt_q - 3'h1;
    end
    cpu_stall_d = (stall_cnt_d != 3'h0);

    // Sticky events, set wins over clear
    ev_set = '0;
    ev_set[nac_pkg::EV_PROG_DONE] = prog_done;
    ev_set[nac_pkg::EV_READ_DONE] = re_q;
    ev_set[nac_pkg::EV_REFUSED]   = pe_req && !start_ok;
    ev_d  = (ev_q & ~ev_clr) | ev_set;
    irq_d = |(ev_d & mask_d);
    rdy_d = rie_d && gie_d && (eng_d == nac_pkg::ENG_IDLE);

    // Read channel
    arready_d = arready_q;
    rvalid_d  = rvalid_q;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    rd_idx_d  = rd_idx_q;
    if (s_axi_arvalid && arready_q) begin
      unique case (s_axi_araddr[7:2])
        nac_pkg::IDX_CTRL: begin
          rv[nac_pkg::CTRL_PM_HI:nac_pkg::CTRL_PM_LO] = mode_q;
          rv[nac_pkg::CTRL_RIE] = rie_q;
          rv[nac_pkg::CTRL_MPE] = mpe_q;
          rv[nac_pkg::CTRL_PE]  = busy;
          rv[nac_pkg::CTRL_RE]  = re_q;
        end
        nac_pkg::IDX_DATA:    rv[7:0] = data_q;
        nac_pkg::IDX_ADDR_LO: rv[7:0] = addr_q[7:0];
        nac_pkg::IDX_ADDR_HI: rv[3:0] = addr_q[11:8];
        nac_pkg::IDX_CFG: begin
          rv[nac_pkg::CFG_GIE] = gie_q;
          rv[nac_pkg::CFG_SPB] = self_program_busy;
        end
        nac_pkg::IDX_STATUS:  rv[EW-1:0] = ev_q;
        nac_pkg::IDX_MASK:    rv[EW-1:0] = mask_q;
        default: ;
      endcase
      rvalid_d  = 1'b1;
      arready_d = 1'b0;
      rdata_d   = rv;
      rd_idx_d  = s_axi_araddr[7:2];
      rresp_d   = idx_ok(s_axi_araddr[7:2]) ? nac_pkg::RESP_OKAY
                                            : nac_pkg::RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d  = 1'b0;
      arready_d = 1'b1;
    end else if (!rvalid_q) begin
      arready_d = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_full_q   <= 1'b0;
      aw_idx_q    <= 6'h00;
      w_full_q    <= 1'b0;
      wdat_q      <= 8'h00;
      wstb_q      <= 1'b0;
      awready_q   <= 1'b0;
      wready_q    <= 1'b0;
      bvalid_q    <= 1'b0;
      bresp_q     <= nac_pkg::RESP_OKAY;
      arready_q   <= 1'b0;
      rvalid_q    <= 1'b0;
      rdata_q     <= 32'h0000_0000;
      rresp_q     <= nac_pkg::RESP_OKAY;
      rd_idx_q    <= 6'h00;
      data_q      <= nac_pkg::RST_DATA;
      addr_q      <= nac_pkg::RST_ADDR;
      rie_q       <= 1'b0;
      mpe_q       <= 1'b0;
      mpe_cnt_q   <= 2'h0;
      re_q        <= 1'b0;
      gie_q       <= 1'b0;
      ev_q        <= '0;
      mask_q      <= '0;
      stall_cnt_q <= 3'h0;
      cpu_stall_q <= 1'b0;
      irq_q       <= 1'b0;
      rdy_q       <= 1'b0;
    end else begin
      aw_full_q   <= aw_full_d;
      aw_idx_q    <= aw_idx_d;
      w_full_q    <= w_full_d;
      wdat_q      <= wdat_d;
      wstb_q      <= wstb_d;
      awready_q   <= awready_d;
      wready_q    <= wready_d;
      bvalid_q    <= bvalid_d;
      bresp_q     <= bresp_d;
      arready_q   <= arready_d;
      rvalid_q    <= rvalid_d;
      rdata_q     <= rdata_d;
      rresp_q     <= rresp_d;
      rd_idx_q    <= rd_idx_d;
      data_q      <= data_d;
      addr_q      <= addr_d;
      rie_q       <= rie_d;
      mpe_q       <= mpe_d;
      mpe_cnt_q   <= mpe_cnt_d;
      re_q        <= re_d;
      gie_q       <= gie_d;
      ev_q        <= ev_d;
      mask_q      <= mask_d;
      stall_cnt_q <= stall_cnt_d;
      cpu_stall_q <= cpu_stall_d;
      irq_q       <= irq_d;
      rdy_q       <= rdy_d;
    end
  end

  // Engine keeps running through system reset
  always_ff @(posedge clk or posedge por) begin
    if (por) begin
      eng_q  <= nac_pkg::ENG_IDLE;
      mode_q <= nac_pkg::RST_MODE;
      tmr_q  <= '0;
      pa_q   <= nac_pkg::RST_ADDR;
      pd_q   <= nac_pkg::RST_DATA;
      el_q   <= '0;
    end else begin
      eng_q  <= eng_d;
      mode_q <= mode_d;
      tmr_q  <= tmr_d;
      pa_q   <= pa_d;
      pd_q   <= pd_d;
      el_q   <= el_d;
    end
  end

  always_ff @(posedge clk) begin
    if (mem_we) begin
      mem[pa_q] <= mem_wd;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign irq           = irq_q;
  assign ready_irq     = rdy_q;
  assign cpu_stall     = cpu_stall_q;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || por);

  property p_rsvd_zero;
    rvalid_q && (rd_idx_q == nac_pkg::IDX_CTRL
      || rd_idx_q == nac_pkg::IDX_ADDR_HI) |-> rdata_q[31:6] == 26'h0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("Reserved bits read nonzero");

  property p_mode_frozen;
    busy ##1 busy |-> $stable(mode_q);
  endproperty
  a_mode_frozen: assert property (p_mode_frozen)
    else $error("Mode changed while programming");

  property p_mpe_window;
    $rose(mpe_q) |-> mpe_q [*4] ##1 !mpe_q;
  endproperty
  a_mpe_window: assert property (p_mpe_window)
    else $error("Master enable not cleared after four cycles");

  property p_start_gated;
    $rose(busy) |-> $past(mpe_q) && !$past(self_program_busy);
  endproperty
  a_start_gated: assert property (p_start_gated)
    else $error("Programming started outside enable window");

  property p_spb_block;
    self_program_busy |=> !$rose(busy);
  endproperty
  a_spb_block: assert property (p_spb_block)
    else $error("Programming started while flash busy");

  property p_prog_stall;
    $rose(busy) |-> cpu_stall [*2] ##1 !cpu_stall;
  endproperty
  a_prog_stall: assert property (p_prog_stall)
    else $error("Programming stall not two cycles");

  property p_read_fetch;
    re_q |=> data_q == $past(mem_rd) ##0 cpu_stall [*4] ##1 !cpu_stall;
  endproperty
  a_read_fetch: assert property (p_read_fetch)
    else $error("Read fetch or stall wrong");

  property p_re_clear;
    re_q |=> !re_q;
  endproperty
  a_re_clear: assert property (p_re_clear)
    else $error("Read strobe did not clear");

  property p_addr_lock;
    busy |=> $stable(addr_q) && !re_q;
  endproperty
  a_addr_lock: assert property (p_addr_lock)
    else $error("Address or read changed while programming");

  property p_prog_time;
    $fell(busy) |-> el_q == ((mode_q == nac_pkg::PM_ATOMIC)
                             ? PROG_ATOMIC_CYC : PROG_SPLIT_CYC);
  endproperty
  a_prog_time: assert property (p_prog_time)
    else $error("Programming time wrong for mode");

  property p_ready_irq;
    busy |-> !ready_irq;
  endproperty
  a_ready_irq: assert property (p_ready_irq)
    else $error("Ready interrupt while programming");

  c_prog: cover property ($rose(busy));
  c_read: cover property (re_q ##1 cpu_stall);
  c_refused: cover property (ev_set[nac_pkg::EV_REFUSED]);
  c_irq: cover property ($rose(irq_q));
endmodule
`default_nettype wire

// ---- verification/nac_top_test.sv ----
// Self-checking bench for the nonvolatile access block.
// Assumes nac_top with shortened programming times and AXI4-Lite access.
`timescale 1ns/1ps
`default_nettype none
module nac_top_test;
  localparam int ATOM = 20;
  localparam int SPLT = 10;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        por = 1'b1;
  logic [7:0]  awaddr = 8'h00;
  logic        awvalid = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic        wvalid = 1'b0;
  logic [7:0]  araddr = 8'h00;
  logic        arvalid = 1'b0;
  logic        spb = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        irq, rdy_irq, stall;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [34:0] exp_r[$];
  logic [1:0]  exp_b[$];
  logic [34:0] er;
  logic [11:0] addr;
  logic [7:0]  d, e, m, v;
  int          n_fail = 0, check_count = 0, seed = 57, i, nb, ns;
  int          busy_cnt = 0, busy_len = 0, n_busy = 0;
  int          st_cnt = 0, st_len = 0, n_st = 0;

  nac_top #(.PROG_ATOMIC_CYC(20'h14), .PROG_SPLIT_CYC(20'h0A)) DUT (
    .clk(clk), .rst(rst), .por(por),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(1'b1), .self_program_busy(spb), .irq(irq),
    .ready_irq(rdy_irq), .cpu_stall(stall));

  always #2.5 clk = ~clk;

  task automatic check(string n, logic [33:0] s, logic [33:0] x);
    check_count++;
    if (s !== x) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, s);
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic timeout();
    n_fail++;
    $display("CHECK FAILED wait expected answer seen timeout");
    finish_test();
  endtask

  task automatic wait_on(ref int cnt, input int k);
    for (int j = 0; j < 300 && cnt == k; j++) @(posedge clk);
    if (cnt == k) timeout();
  endtask

  // Write with both channels offered together
  task automatic wr(logic [7:0] a, logic [7:0] dat, logic [1:0] rsp = 2'h0);
    int k;
    exp_b.push_back(rsp);
    awaddr <= a;
    wdata <= {24'h0, dat};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (k == 50) timeout();
  endtask

  // Read; expectation noted for the monitor
  task automatic rd(logic [7:0] a, logic [7:0] x, logic c = 1'b1,
                    logic [1:0] rsp = 2'h0);
    int k;
    exp_r.push_back({c, rsp, 24'h0, x});
    araddr <= a;
    arvalid <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (k == 50) timeout();
    v = rdata[7:0];
  endtask

  task automatic start(logic [1:0] md);
    nb = n_busy;
    ns = n_st;
    wr(8'h7C, {2'h0, md, 4'hC});
    wr(8'h7C, {2'h0, md, 4'hA});
  endtask

  task automatic done(int len);
    wait_on(n_busy, nb);
    check("busy", busy_len, len);
    check("stall", st_len, 2);
  endtask

  task automatic settle();
    @(posedge clk);
    #1;
  endtask

  // Run lengths and bus answers
  always @(posedge clk) begin
    if (rdy_irq === 1'b0) begin
      busy_cnt <= busy_cnt + 1;
    end else if (busy_cnt != 0) begin
      busy_len <= busy_cnt;
      busy_cnt <= 0;
      n_busy <= n_busy + 1;
    end
    if (stall === 1'b1) begin
      st_cnt <= st_cnt + 1;
    end else if (st_cnt != 0) begin
      st_len <= st_cnt;
      st_cnt <= 0;
      n_st <= n_st + 1;
    end
    if (bvalid === 1'b1) check("bresp", bresp, exp_b.pop_front());
    if (rvalid === 1'b1) begin
      er = exp_r.pop_front();
      if (er[34]) check("rdata", {rresp, rdata}, er[33:0]);
    end
  end

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    por <= 1'b0;
    repeat (2) @(posedge clk);
    rd(8'h80, 8'h00);
    rd(8'h7C, 8'h00);
    wr(8'h88, 8'hFF);
    rd(8'h88, 8'h0F);
    wr(8'h00, 8'h00, 2'h2);
    rd(8'hFC, 8'h00, 1'b1, 2'h2);
    $display("test registers done");
    wr(8'h8C, 8'h01);
    wr(8'h94, 8'h07);
    wr(8'h7C, 8'h08);
    addr = 12'($random(seed));
    wr(8'h84, addr[7:0]);
    wr(8'h88, {4'h0, addr[11:8]});
    rd(8'h84, addr[7:0]);
    e = 8'h00;
    for (i = 0; i < 4; i++) begin
      m = (i == 0) ? 8'h00 : (i == 1) ? 8'h01 : 8'h02;
      d = 8'($random(seed));
      e = (m == 8'h00) ? d : (m == 8'h01) ? 8'hFF : (e & d);
      wr(8'h80, d);
      start(m[1:0]);
      done((m == 8'h00) ? ATOM : SPLT);
      settle();
      check("irq", irq, 1'b1);
      wr(8'h90, 8'h07);
      ns = n_st;
      wr(8'h7C, 8'h09);
      wait_on(n_st, ns);
      check("stall", st_len, 4);
      rd(8'h80, e);
      rd(8'h7C, 8'h08);
    end
    $display("test program modes done");
    start(2'h0);
    wr(8'h7C, 8'h1A);
    wr(8'h84, ~addr[7:0]);
    rd(8'h7C, 8'h0A);
    done(ATOM);
    rd(8'h84, addr[7:0]);
    $display("test busy lockout done");
    wr(8'h90, 8'h07);
    wr(8'h7C, 8'h0C);
    repeat (6) @(posedge clk);
    rd(8'h7C, 8'h08);
    wr(8'h7C, 8'h0A);
    rd(8'h7C, 8'h08);
    rd(8'h90, 8'h04);
    settle();
    check("irq", irq, 1'b1);
    wr(8'h94, 8'h00);
    settle();
    check("irq", irq, 1'b0);
    wr(8'h94, 8'h07);
    wr(8'h90, 8'h07);
    settle();
    check("irq", irq, 1'b0);
    spb <= 1'b1;
    start(2'h0);
    rd(8'h8C, 8'h03);
    rd(8'h90, 8'h04);
    spb <= 1'b0;
    wr(8'h90, 8'h07);
    start(2'h3);
    rd(8'h90, 8'h04);
    wr(8'h8C, 8'h00);
    settle();
    check("ready_irq", rdy_irq, 1'b0);
    wr(8'h8C, 8'h01);
    settle();
    check("ready_irq", rdy_irq, 1'b1);
    $display("test enable window done");
    start(2'h2);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    rd(8'h7C, 8'h22);
    for (i = 0; i < 40 && v[1] === 1'b1; i++) rd(8'h7C, 8'h00, 1'b0);
    rd(8'h7C, 8'h20);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    rd(8'h7C, 8'h00);
    $display("test reset hold done");
    finish_test();
  end
endmodule
`default_nettype wire
